// File: shared/fpl_pkg.sv
/*
  Package for the fast parallel configuration loader: register map, field
  positions, reset values, state encoding and timing counts.
  Assumes a single 100 MHz register clock; all times are converted to it here.
*/
`default_nettype none

package fpl_pkg;

  // ****************************************************************
  // register map (byte addresses, one 32-bit word each)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IMAGE_WORDS = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_WORD_COUNT = 8'h0C;
  localparam logic [7:0] OFS_CHECKSUM = 8'h10;
  localparam logic [7:0] OFS_USER_OUT = 8'h14;
  localparam logic [7:0] OFS_USER_OE = 8'h18;

  // ctrl fields
  localparam int CTRL_WIDTH_LSB = 0;
  localparam int CTRL_DECOMP_BIT = 2;
  localparam int CTRL_SECURE_BIT = 3;
  localparam int CTRL_USRCLK_BIT = 4;
  localparam int CTRL_INITPIN_BIT = 5;
  localparam int CTRL_BITS = 6;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // bus width codes
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;

  localparam int WORD_BITS = 24;
  localparam logic [23:0] IMAGE_WORDS_RESET = 24'h000100;

  // ****************************************************************
  // load states, gray coded along the normal path
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_CLEAR = 3'h1,
    ST_LOAD = 3'h3,
    ST_EDGES = 3'h2,
    ST_INIT = 3'h6,
    ST_USER = 3'h7
  } fpl_state_t;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int STATUS_MIN_US = 268;
  localparam int STATUS_MIN_CYCLES = STATUS_MIN_US * CLK_MHZ;
  localparam int INIT_OSC_MIN_US = 175;
  localparam int INIT_OSC_CYCLES = INIT_OSC_MIN_US * CLK_MHZ;
  localparam int LOAD_CLK_MAX_PERIOD_NS = 10;
  localparam int USRCLK_DELAY_NS = 4 * LOAD_CLK_MAX_PERIOD_NS;
  localparam int USRCLK_DELAY_CYCLES = (USRCLK_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int USER_INIT_PERIODS = 8576;
  localparam int POR_CYCLES = 1000;
  localparam int TIMER_BITS = 18;
  localparam int INIT_FALL_EDGES = 2;

endpackage : fpl_pkg

`default_nettype wire

// File: logic/fpl_sync2.sv
/*
  Two flip-flop synchroniser for a bundle of independent levels.
  Assumes each bit is quasi-static relative to the sampling clock.
*/
`default_nettype none

module fpl_sync2 #(
  parameter int W = 1
) (
  input wire logic clk, // sampling clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] rst_val, // unused; reset always loads zero whatever this is
  input wire logic [W-1:0] d, // asynchronous inputs
  output logic [W-1:0] q // synchronised outputs
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

  // rst_val is unused as a reset source: async reset must load constants
  logic unused_rv;
  assign unused_rv = ^rst_val;

endmodule : fpl_sync2

`default_nettype wire

// File: logic/fpl_ratio.sv
/*
  Load-clock cycles per data word for the chosen bus width and feature set.
  Purely combinational; assumes the width code is one of 8, 16 or 32 bits.
*/
`default_nettype none

module fpl_ratio (
  input wire logic [1:0] width, // bus width code
  input wire logic decomp, // decompression enabled
  input wire logic secure, // security enabled
  output logic [3:0] ratio // clocks per word
);

  // ****************************************************************
  // ratio table
  // ****************************************************************
  always_comb
  begin
    ratio = 4'h1;
    case (width)
      fpl_pkg::WIDTH_8: ratio = decomp ? 4'h2 : 4'h1;
      fpl_pkg::WIDTH_16: ratio = decomp ? 4'h4 : (secure ? 4'h2 : 4'h1);
      fpl_pkg::WIDTH_32: ratio = decomp ? 4'h8 : (secure ? 4'h4 : 4'h1);
      default: ratio = 4'h1;
    endcase
  end

endmodule : fpl_ratio

`default_nettype wire

// File: logic/fpl_top.sv
/*
  Fast parallel configuration loader, device side, with an APB register port.
  Assumes reload request, status, done, load clock, user init clock and data
  pins all arrive asynchronously and are sampled by pclk (100 MHz).
*/
// The register addresses and the APB register port were decided locally.
`default_nettype none

module fpl_top #(
  parameter int STATUS_MIN_CYCLES = fpl_pkg::STATUS_MIN_CYCLES, // least status low time
  parameter int INIT_OSC_CYCLES = fpl_pkg::INIT_OSC_CYCLES, // internal init time
  parameter int USER_INIT_PERIODS = fpl_pkg::USER_INIT_PERIODS, // user clock periods
  parameter int POR_CYCLES = fpl_pkg::POR_CYCLES // power-on hold
) (
  input wire logic pclk, // register clock
  input wire logic presetn, // async reset, active low
  input wire logic [7:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic reload_req_n, // reload request pin
  input wire logic status_n_in, // status pin level
  output logic status_n_out, // status pin drive value
  output logic status_n_oe, // status pin drive enable
  input wire logic done_in, // done pin level
  output logic done_out, // done pin drive value
  output logic done_oe, // done pin drive enable
  input wire logic load_clock, // load clock pin
  input wire logic user_init_clock, // user init clock pin
  input wire logic [31:0] load_data_in, // data bus pin levels
  output logic [31:0] load_data_out, // data pins as user outputs
  output logic [31:0] load_data_oe, // data pins user drive enables
  output logic init_done_n_out, // init pin drive value
  output logic init_done_n_oe, // init pin drive enable
  output logic user_mode // device is in user mode
);

  // ****************************************************************
  // state record
  // ****************************************************************
  typedef struct packed {
    fpl_pkg::fpl_state_t state;
    logic [fpl_pkg::TIMER_BITS-1:0] timer;
    logic [3:0] phase;
    logic [fpl_pkg::WORD_BITS-1:0] words;
    logic [1:0] falls;
    logic usr_phase;
    logic [13:0] usr_cnt;
    logic lclk_prev;
    logic uclk_prev;
    logic initpin_armed;
    logic [fpl_pkg::CTRL_BITS-1:0] ctrl;
    logic [fpl_pkg::WORD_BITS-1:0] image_words;
    logic [31:0] checksum;
    logic [31:0] user_out;
    logic [31:0] user_oe;
    logic [31:0] prdata;
  } fpl_regs_t;

  fpl_regs_t r_q;
  fpl_regs_t r_d;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [4:0] pins_s;
  logic [31:0] data_s;

  fpl_sync2 #(.W(5)) u_sync_pins (
    .clk(pclk),
    .rst_n(presetn),
    .rst_val(5'h00),
    .d({reload_req_n, status_n_in, done_in, load_clock, user_init_clock}),
    .q(pins_s)
  );

  // data and clock share the same latency so the word lines up with its edge
  fpl_sync2 #(.W(32)) u_sync_data (
    .clk(pclk),
    .rst_n(presetn),
    .rst_val(32'h00000000),
    .d(load_data_in),
    .q(data_s)
  );

  logic reload_s;
  logic status_s;
  logic lclk_s;
  logic uclk_s;
  assign reload_s = pins_s[4];
  assign status_s = pins_s[3];
  assign lclk_s = pins_s[1];
  assign uclk_s = pins_s[0];

  // done_in is sampled for completeness; device owns the done decision
  logic unused_done;
  assign unused_done = pins_s[2];

  // ****************************************************************
  // ratio lookup
  // ****************************************************************
  logic [3:0] ratio;

  fpl_ratio u_ratio (
    .width(r_q.ctrl[fpl_pkg::CTRL_WIDTH_LSB +: 2]),
    .decomp(r_q.ctrl[fpl_pkg::CTRL_DECOMP_BIT]),
    .secure(r_q.ctrl[fpl_pkg::CTRL_SECURE_BIT]),
    .ratio(ratio)
  );

  // mask the captured word to the active lanes
  function automatic logic [31:0] fpl_lane_mask(input logic [1:0] width);
    case (width)
      fpl_pkg::WIDTH_8: fpl_lane_mask = 32'h000000FF;
      fpl_pkg::WIDTH_16: fpl_lane_mask = 32'h0000FFFF;
      default: fpl_lane_mask = 32'hFFFFFFFF;
    endcase
  endfunction : fpl_lane_mask

  logic lclk_rise;
  logic lclk_fall;
  logic uclk_rise;
  assign lclk_rise = lclk_s & ~r_q.lclk_prev;
  assign lclk_fall = ~lclk_s & r_q.lclk_prev;
  assign uclk_rise = uclk_s & ~r_q.uclk_prev;

  logic apb_setup;
  logic apb_write;
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite;

  logic addr_ok;
  always_comb
  begin
    case (paddr)
      fpl_pkg::OFS_CTRL,
      fpl_pkg::OFS_IMAGE_WORDS,
      fpl_pkg::OFS_STATUS,
      fpl_pkg::OFS_WORD_COUNT,
      fpl_pkg::OFS_CHECKSUM,
      fpl_pkg::OFS_USER_OUT,
      fpl_pkg::OFS_USER_OE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb
  begin
    r_d = r_q;
    r_d.lclk_prev = lclk_s;
    r_d.uclk_prev = uclk_s;

    // read data captured in setup so it comes from a flop in the access phase
    if (apb_setup)
    begin
      case (paddr)
        fpl_pkg::OFS_CTRL: r_d.prdata = {26'h0000000, r_q.ctrl};
        fpl_pkg::OFS_IMAGE_WORDS: r_d.prdata = {8'h00, r_q.image_words};
        fpl_pkg::OFS_STATUS: r_d.prdata = {24'h000000, ratio, user_mode, r_q.state};
        fpl_pkg::OFS_WORD_COUNT: r_d.prdata = {8'h00, r_q.words};
        fpl_pkg::OFS_CHECKSUM: r_d.prdata = r_q.checksum;
        fpl_pkg::OFS_USER_OUT: r_d.prdata = r_q.user_out;
        fpl_pkg::OFS_USER_OE: r_d.prdata = r_q.user_oe;
        default: r_d.prdata = 32'h00000000;
      endcase
    end

    // setup writes are refused mid-load: ratio and length must stay fixed
    if (apb_write && r_q.state != fpl_pkg::ST_LOAD)
    begin
      case (paddr)
        fpl_pkg::OFS_CTRL: r_d.ctrl = pwdata[fpl_pkg::CTRL_BITS-1:0];
        fpl_pkg::OFS_IMAGE_WORDS: r_d.image_words = pwdata[fpl_pkg::WORD_BITS-1:0];
        default: ;
      endcase
    end
    if (apb_write)
    begin
      case (paddr)
        fpl_pkg::OFS_USER_OUT: r_d.user_out = pwdata;
        fpl_pkg::OFS_USER_OE: r_d.user_oe = pwdata;
        default: ;
      endcase
    end

    if (r_q.timer != '0)
    begin
      r_d.timer = r_q.timer - 1'b1;
    end

    case (r_q.state)
      // hold status low for the power-on delay, then behave as a fresh clear
      fpl_pkg::ST_POR:
      begin
        if (r_q.timer == '0)
        begin
          r_d.state = fpl_pkg::ST_CLEAR;
          r_d.timer = fpl_pkg::TIMER_BITS'(STATUS_MIN_CYCLES);
        end
      end
      // status low for the least time and while the request is still low;
      // an external hold on status simply keeps us here
      fpl_pkg::ST_CLEAR:
      begin
        if (!reload_s)
        begin
          r_d.timer = fpl_pkg::TIMER_BITS'(STATUS_MIN_CYCLES);
        end
        else if (r_q.timer == '0 && status_s)
        begin
          r_d.state = fpl_pkg::ST_LOAD;
          r_d.words = '0;
          r_d.phase = '0;
          r_d.checksum = 32'h00000000;
        end
      end
      // one word per ratio rising edges, taken on the first of each group
      fpl_pkg::ST_LOAD:
      begin
        if (lclk_rise)
        begin
          if (r_q.phase == 4'h0)
          begin
            r_d.checksum = r_q.checksum + (data_s & fpl_lane_mask(r_q.ctrl[fpl_pkg::CTRL_WIDTH_LSB +: 2]));
            r_d.words = r_q.words + 1'b1;
            r_d.initpin_armed = r_q.ctrl[fpl_pkg::CTRL_INITPIN_BIT];
          end
          r_d.phase = (r_q.phase + 4'h1 == ratio) ? 4'h0 : r_q.phase + 4'h1;
          // done waits out the processing clocks that follow the last word
          if (r_q.phase + 4'h1 == ratio && r_d.words == r_q.image_words)
          begin
            r_d.state = fpl_pkg::ST_EDGES;
            r_d.falls = 2'h0;
          end
        end
      end
      // done is high now; wait for the falling edges that start init
      fpl_pkg::ST_EDGES:
      begin
        if (lclk_fall)
        begin
          r_d.falls = r_q.falls + 2'h1;
          if (r_q.falls + 2'h1 == 2'(fpl_pkg::INIT_FALL_EDGES))
          begin
            r_d.state = fpl_pkg::ST_INIT;
            r_d.usr_phase = 1'b0;
            r_d.usr_cnt = '0;
            r_d.timer = r_q.ctrl[fpl_pkg::CTRL_USRCLK_BIT] ?
              fpl_pkg::TIMER_BITS'(fpl_pkg::USRCLK_DELAY_CYCLES) :
              fpl_pkg::TIMER_BITS'(INIT_OSC_CYCLES);
          end
        end
      end
      // initialization on the internal timer or on counted user clock periods
      fpl_pkg::ST_INIT:
      begin
        if (!r_q.ctrl[fpl_pkg::CTRL_USRCLK_BIT])
        begin
          if (r_q.timer == '0)
          begin
            r_d.state = fpl_pkg::ST_USER;
          end
        end
        else if (!r_q.usr_phase)
        begin
          if (r_q.timer == '0)
          begin
            r_d.usr_phase = 1'b1;
          end
        end
        else if (uclk_rise)
        begin
          r_d.usr_cnt = r_q.usr_cnt + 14'h0001;
          if (r_q.usr_cnt + 14'h0001 == 14'(USER_INIT_PERIODS))
          begin
            r_d.state = fpl_pkg::ST_USER;
          end
        end
      end
      // load clock is no longer looked at here
      fpl_pkg::ST_USER: ;
      default: r_d.state = fpl_pkg::ST_POR;
    endcase

    // a low request restarts the load from any state but power-on
    if (!reload_s && r_q.state != fpl_pkg::ST_POR)
    begin
      r_d.state = fpl_pkg::ST_CLEAR;
      r_d.timer = fpl_pkg::TIMER_BITS'(STATUS_MIN_CYCLES);
      r_d.initpin_armed = 1'b0;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_q <= '0;
      r_q.state <= fpl_pkg::ST_POR;
      r_q.timer <= fpl_pkg::TIMER_BITS'(POR_CYCLES);
      r_q.ctrl <= fpl_pkg::CTRL_RESET;
      r_q.image_words <= fpl_pkg::IMAGE_WORDS_RESET;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // apb: zero wait states, unmapped addresses flagged in the access phase
  assign prdata = r_q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // pull low through power-on and the clear time, then let go so the pin can rise;
  // an outside hold keeps the pin low and the load waits in clear
  assign status_n_out = 1'b0;
  assign status_n_oe = (r_q.state == fpl_pkg::ST_POR) ||
                       ((r_q.state == fpl_pkg::ST_CLEAR) && (r_q.timer != '0));

  // done held low until the whole image has been counted in
  assign done_out = 1'b0;
  assign done_oe = (r_q.state == fpl_pkg::ST_POR) || (r_q.state == fpl_pkg::ST_CLEAR) ||
                   (r_q.state == fpl_pkg::ST_LOAD);

  // init pin low once its option is loaded, until user mode
  assign init_done_n_out = 1'b0;
  assign init_done_n_oe = r_q.initpin_armed && (r_q.state != fpl_pkg::ST_USER);

  assign user_mode = (r_q.state == fpl_pkg::ST_USER);

  // data pins turn into user pins only in user mode
  assign load_data_out = r_q.user_out;
  assign load_data_oe = user_mode ? r_q.user_oe : 32'h00000000;

endmodule : fpl_top

`default_nettype wire

// File: test/fpl_top_asserts.sv
/*
  Checker for the loader's status, done, init and user-pin behaviour.
  Assumes it is bound to fpl_top and sees only that module's ports.
*/
`default_nettype none

module fpl_chk #(
  parameter int STATUS_MIN_CYCLES = 20, // least status low time
  parameter int POR_CYCLES = 10 // power-on hold
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic reload_req_n, // reload request pin
  input wire logic status_n_oe, // status pull enable
  input wire logic done_oe, // done pull enable
  input wire logic [31:0] load_data_oe, // user pin enables
  input wire logic init_done_n_oe, // init pin pull enable
  input wire logic user_mode // user mode flag
);
  // ****************************************************************
  // helper counters and properties
  // ****************************************************************
  int lo_cnt; // cycles status has been pulled low
  int hi_cnt; // cycles status held while request released
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // plain counters; runs are far too short to wrap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lo_cnt <= 0;
      hi_cnt <= 0;
    end
    else
    begin
      lo_cnt <= status_n_oe ? lo_cnt + 1 : 0;
      hi_cnt <= (status_n_oe && reload_req_n) ? hi_cnt + 1 : 0;
    end
  end

  property p_done_pull;
    $fell(reload_req_n) && user_mode |-> ##[1:60] done_oe;
  endproperty
  a_done_pull: assert property (p_done_pull) else $error("done not pulled low in time");
  property p_status_pull;
    $fell(reload_req_n) && user_mode |-> ##[1:60] status_n_oe;
  endproperty
  a_status_pull: assert property (p_status_pull) else $error("status not pulled low in time");
  property p_status_min;
    $fell(status_n_oe) |-> lo_cnt >= STATUS_MIN_CYCLES;
  endproperty
  a_status_min: assert property (p_status_min) else $error("status low pulse too short");
  property p_status_max;
    hi_cnt <= STATUS_MIN_CYCLES + POR_CYCLES + 16;
  endproperty
  a_status_max: assert property (p_status_max) else $error("status held too long");
  property p_por_hold;
    $rose(presetn) |-> status_n_oe [*8];
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("status not held after power-up");
  property p_user_idle;
    user_mode |-> !status_n_oe && !done_oe;
  endproperty
  a_user_idle: assert property (p_user_idle) else $error("pins pulled low in user mode");
  property p_done_ok;
    $fell(done_oe) |-> !status_n_oe && !user_mode;
  endproperty
  a_done_ok: assert property (p_done_ok) else $error("done released outside a good load");
  property p_pins_off;
    !user_mode |-> load_data_oe == 32'h00000000;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("user pins driven before user mode");
  property p_init_pin;
    init_done_n_oe |-> !user_mode;
  endproperty
  a_init_pin: assert property (p_init_pin) else $error("init pin low in user mode");
endmodule : fpl_chk

bind fpl_top fpl_chk #(.STATUS_MIN_CYCLES(STATUS_MIN_CYCLES), .POR_CYCLES(POR_CYCLES)) i_fpl_chk (.pclk,
  .presetn, .reload_req_n, .status_n_oe, .done_oe, .load_data_oe, .init_done_n_oe, .user_mode);

`default_nettype wire

// File: test/fpl_host.sv
/*
  Behavioural configuration host driving request, load clock and data.
  Assumes pclk at 100 MHz paces it; load clock period is 160 ns.
*/
`default_nettype none

module fpl_host (
  input wire logic pclk, // pacing clock
  input wire logic status_n_in, // status pin level
  input wire logic done_in, // done pin level
  output logic reload_req_n, // reload request
  output logic load_clock, // load clock, still outside frames
  output logic user_init_clock, // user init clock
  output logic [31:0] load_data_in // data bus
);
  // ****************************************************************
  // host sequences
  // ****************************************************************
  initial
  begin
    reload_req_n = 1'b1;
    load_clock = 1'b0;
    user_init_clock = 1'b0;
    load_data_in = 32'h00000000;
  end

  // half a load clock period
  task automatic half();
    repeat (8) @(posedge pclk);
  endtask : half

  // wait for status, then leave 2 us before the first edge
  task automatic ready();
    for (int t = 0; t < 2000 && status_n_in !== 1'b1; t++) @(posedge pclk);
    repeat (200) @(posedge pclk);
  endtask : ready

  task automatic restart();
    reload_req_n <= 1'b0;
    repeat (200) @(posedge pclk);
    reload_req_n <= 1'b1;
    ready();
  endtask : restart

  // one word, held through all r clocks of it
  task automatic put_word(input logic [31:0] w, input int r);
    load_data_in <= w;
    for (int k = 0; k < r; k++)
    begin
      half();
      load_clock <= 1'b1;
      half();
      load_clock <= 1'b0;
    end
  endtask : put_word

  // two falls after done, then optional user clock after a gap
  task automatic finish(input logic usr, input int np);
    load_data_in <= ~load_data_in;
    for (int k = 0; k < 2; k++)
    begin
      half();
      load_clock <= 1'b1;
      half();
      load_clock <= 1'b0;
    end
    repeat (8) @(posedge pclk);
    for (int k = 0; usr && k < np; k++)
    begin
      half();
      user_init_clock <= 1'b1;
      half();
      user_init_clock <= 1'b0;
    end
  endtask : finish
endmodule : fpl_host

`default_nettype wire

// File: test/tb.sv
/*
  Self-checking bench: loads every width with each decompression and security mix over the pins.
  Assumes fpl_host as the far side and shortened timing parameters.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // stimulus and checks
  // ****************************************************************
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, load_data_out, load_data_oe, load_data_in, w, m, sum, rdv, cv;
  logic pready, pslverr, status_n_out, status_n_oe, done_out, done_oe, init_done_n_out, init_done_n_oe;
  logic user_mode, reload_req_n, load_clock, user_init_clock, err, usr;
  wire logic status_n_in = status_n_oe ? status_n_out : 1'b1; // pulled up
  wire logic done_in = done_oe ? done_out : 1'b1; // pulled up
  wire logic init_pin = init_done_n_oe ? init_done_n_out : 1'b1; // pulled up
  int seed = 69, error_cnt = 0, num_checks = 0, n, r;

  fpl_top #(.STATUS_MIN_CYCLES(20), .INIT_OSC_CYCLES(20), .USER_INIT_PERIODS(4), .POR_CYCLES(10)) i_fpl_top (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .reload_req_n,
    .status_n_in, .status_n_out, .status_n_oe, .done_in, .done_out, .done_oe, .load_clock, .user_init_clock,
    .load_data_in, .load_data_out, .load_data_oe, .init_done_n_out, .init_done_n_oe, .user_mode);
  fpl_host i_fpl_host (.pclk, .status_n_in, .done_in, .reload_req_n, .load_clock, .user_init_clock,
    .load_data_in);

  always #5 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer; an idle cycle follows so strobes never double up
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  function automatic int ratio(input logic [1:0] wd, input logic dc, input logic sc);
    if (wd == fpl_pkg::WIDTH_8) return dc ? 2 : 1;
    if (wd == fpl_pkg::WIDTH_16) return dc ? 4 : (sc ? 2 : 1);
    return dc ? 8 : (sc ? 4 : 1);
  endfunction : ratio

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // watchdog well beyond the expected run of under 100 us
  initial
  begin
    #500us;
    error_cnt++;
    conclude();
  end

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, fpl_pkg::OFS_CTRL, 32'h0);
    chk("ctrl reset", rdv, 32'h00000000);
    apb(1'b0, fpl_pkg::OFS_IMAGE_WORDS, 32'h0);
    chk("words reset", rdv, 32'h00000100);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h00000001);
    for (int c = 0; c < 12; c++)
    begin
      r = ratio(c / 4, c[1], c[0]);
      m = (c < 4) ? 32'h000000FF : ((c < 8) ? 32'h0000FFFF : 32'hFFFFFFFF);
      usr = $random(seed);
      n = 1 + ($random(seed) & 3);
      cv = {26'h0, c[1], usr, c[0], c[1], 2'(c / 4)};
      apb(1'b1, fpl_pkg::OFS_CTRL, cv);
      apb(1'b1, fpl_pkg::OFS_IMAGE_WORDS, 32'(n));
      apb(1'b0, fpl_pkg::OFS_STATUS, 32'h0);
      chk("ratio", {28'h0, rdv[7:4]}, 32'(r));
      if (c > 0)
        i_fpl_host.restart();
      else
        i_fpl_host.ready();
      // the ratio must not move under a running load
      apb(1'b1, fpl_pkg::OFS_CTRL, ~cv);
      apb(1'b0, fpl_pkg::OFS_CTRL, 32'h0);
      chk("ctrl locked", rdv, cv);
      sum = 32'h0;
      for (int k = 0; k < n; k++)
      begin
        w = $random(seed);
        sum = sum + (w & m);
        if (k == n - 1) chk("done early", {31'h0, done_in}, 32'h0);
        i_fpl_host.put_word(w, r);
      end
      for (int t = 0; t < 100 && done_in !== 1'b1; t++) @(posedge pclk);
      chk("done", {31'h0, done_in}, 32'h1);
      chk("init pin", {31'h0, init_pin}, 32'(!c[1]));
      i_fpl_host.finish(usr, 6);
      for (int t = 0; t < 500 && user_mode !== 1'b1; t++) @(posedge pclk);
      chk("user mode", {31'h0, user_mode}, 32'h1);
      chk("init released", {31'h0, init_pin}, 32'h1);
      i_fpl_host.put_word($random(seed), 1);
      apb(1'b0, fpl_pkg::OFS_WORD_COUNT, 32'h0);
      chk("word count", rdv, 32'(n));
      apb(1'b0, fpl_pkg::OFS_CHECKSUM, 32'h0);
      chk("checksum", rdv, sum);
      w = $random(seed);
      apb(1'b1, fpl_pkg::OFS_USER_OE, w);
      chk("user pins", load_data_oe, w);
      apb(1'b1, fpl_pkg::OFS_USER_OUT, ~w);
      chk("user out", load_data_out, ~w);
      $display("config %0d done", c);
    end
    conclude();
  end
endmodule : tb

`default_nettype wire
